// file: rtl/mac_int_defs.svh
// opcode range bounds and operand field positions for the integer mac decoder
`ifndef MAC_INT_DEFS_SVH
`define MAC_INT_DEFS_SVH

// ****************************************************************
// range count
// ****************************************************************
`define MI_NUM_RANGES 26

// ****************************************************************
// signed integer option, even register through accumulator zero
// ****************************************************************
`define MI_LO_00 32'hc10d_0000
`define MI_HI_00 32'hc10d_07ff
`define MI_LO_01 32'hc10d_0800
`define MI_HI_01 32'hc10d_0fff
`define MI_LO_02 32'hc10d_1000
`define MI_HI_02 32'hc10d_17ff

// ****************************************************************
// signed integer option with mixed operands
// ****************************************************************
`define MI_LO_03 32'hc118_1800
`define MI_HI_03 32'hc118_d9ff
`define MI_LO_04 32'hc119_1800
`define MI_HI_04 32'hc119_d9ff
`define MI_LO_05 32'hc11a_1800
`define MI_HI_05 32'hc11a_d9ff
`define MI_LO_06 32'hc11c_2000
`define MI_HI_06 32'hc11f_ffff
`define MI_LO_25 32'hc116_1800
`define MI_HI_25 32'hc116_d9ff

// ****************************************************************
// scaled by two signed integer option
// ****************************************************************
`define MI_LO_07 32'hc123_2000
`define MI_HI_07 32'hc123_27ff
`define MI_LO_08 32'hc123_2800
`define MI_HI_08 32'hc123_2fff
`define MI_LO_09 32'hc123_3000
`define MI_HI_09 32'hc123_37ff
`define MI_LO_10 32'hc127_3800
`define MI_HI_10 32'hc127_39c0
`define MI_LO_11 32'hc128_1800
`define MI_HI_11 32'hc128_d9ff
`define MI_LO_12 32'hc129_1800
`define MI_HI_12 32'hc129_d9ff
`define MI_LO_13 32'hc12a_1800
`define MI_HI_13 32'hc12a_d9ff
`define MI_LO_14 32'hc12d_0800
`define MI_HI_14 32'hc12d_0fff
`define MI_LO_15 32'hc12d_1000
`define MI_HI_15 32'hc12d_17ff

// ****************************************************************
// scaled by two signed integer option with mixed operands
// ****************************************************************
`define MI_LO_16 32'hc134_1800
`define MI_HI_16 32'hc134_d9ff
`define MI_LO_17 32'hc138_1800
`define MI_HI_17 32'hc138_d9ff
`define MI_LO_18 32'hc139_1800
`define MI_HI_18 32'hc139_d9ff
`define MI_LO_19 32'hc13a_1800
`define MI_HI_19 32'hc13a_d9ff
`define MI_LO_20 32'hc13c_2000
`define MI_HI_20 32'hc13f_ffff

// ****************************************************************
// integer upper half option
// ****************************************************************
`define MI_LO_21 32'hc163_2000
`define MI_HI_21 32'hc163_27ff
`define MI_LO_22 32'hc163_2800
`define MI_HI_22 32'hc163_2fff
`define MI_LO_23 32'hc163_3000
`define MI_HI_23 32'hc163_37ff
`define MI_LO_24 32'hc165_1800
`define MI_HI_24 32'hc165_d9ff

// ****************************************************************
// operand field positions in the low opcode bits
// ****************************************************************
`define MI_SRC_B_LSB  0
`define MI_SRC_A_LSB  3
`define MI_DST_LSB    6
`define MI_SRC_B_HIGH 9
`define MI_SRC_A_HIGH 10

`endif

// file: rtl/mac_int_pkg.sv
// types shared by the integer mac opcode decoder
`default_nettype none

package mac_int_pkg;

    // ****************************************************************
    // result destination of a decoded form
    // ****************************************************************
    typedef enum logic [2:0] {
        DST_NONE,
        DST_HALF_LOW,       // data_low_half from accumulator_zero
        DST_HALF_HIGH,      // data_high_half from accumulator_one
        DST_EVEN,           // even full register from accumulator_zero
        DST_ODD,            // odd full register from accumulator_one
        DST_EVEN_ODD,       // paired full registers
        DST_LOW_HIGH        // paired half registers
    } dest_e;

    // ****************************************************************
    // accumulate operator
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ASSIGN,
        OP_ADD,
        OP_SUB,
        OP_PER_LANE,        // operator chosen per lane by low bits
        OP_MOVE             // accumulator to half register copy
    } op_e;

    // ****************************************************************
    // product option
    // ****************************************************************
    typedef enum logic [1:0] {
        OPT_NONE,
        OPT_SIGNED_INTEGER,         // signed_integer_option
        OPT_SIGNED_INTEGER_X2,      // signed_integer_scaled_by_two
        OPT_INTEGER_UPPER_HALF      // integer_upper_half_option
    } option_e;

    // ****************************************************************
    // one table entry
    // ****************************************************************
    typedef struct packed {
        dest_e   dest;
        op_e     op;
        option_e option;
        logic    mixed;
    } form_s;

endpackage

`default_nettype wire

// file: rtl/opcode_range_match.sv
// inclusive bound comparator for one opcode range
`default_nettype none

module opcode_range_match #(
    parameter logic [31:0] LO = 32'h0000_0000,
    parameter logic [31:0] HI = 32'h0000_0000
) (
    // opcode under test
    input  wire logic [31:0] opcode,
    // inside both bounds
    output logic             hit
);

    // ****************************************************************
    // compare
    // ****************************************************************
    // both bounds are inclusive
    assign hit = (opcode >= LO) && (opcode <= HI);

endmodule

`default_nettype wire

// file: rtl/mac_operand_fields.sv
// splits register numbers and half selects out of the low opcode bits
`include "mac_int_defs.svh"
`default_nettype none

module mac_operand_fields (
    // opcode word
    input  wire logic [31:0] opcode,
    // extracted fields
    output logic [2:0]       dst_reg,
    output logic [2:0]       src_a_reg,
    output logic [2:0]       src_b_reg,
    output logic             src_a_high,
    output logic             src_b_high
);

    // ****************************************************************
    // field slices, taken verbatim
    // ****************************************************************
    assign dst_reg    = opcode[`MI_DST_LSB +: 3];
    assign src_a_reg  = opcode[`MI_SRC_A_LSB +: 3];
    assign src_b_reg  = opcode[`MI_SRC_B_LSB +: 3];
    assign src_a_high = opcode[`MI_SRC_A_HIGH];
    assign src_b_high = opcode[`MI_SRC_B_HIGH];

endmodule

`default_nettype wire

// file: rtl/mac_opcode_decoder_int_modes.sv
// decoder for the integer-option multiply-accumulate opcode slice
`include "mac_int_defs.svh"
`default_nettype none

module mac_opcode_decoder_int_modes (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,

    // opcode from the sequencer
    input  wire logic                  opcode_valid,
    input  wire logic [31:0]           opcode,

    // decode outcome
    output logic                       form_valid_r,
    output logic                       other_valid_r,
    output logic [31:0]                other_opcode_r,

    // form description
    output mac_int_pkg::dest_e         dest_r,
    output mac_int_pkg::op_e           op_r,
    output mac_int_pkg::option_e       option_r,
    output logic                       mixed_r,
    output logic                       use_acc_zero_r,
    output logic                       use_acc_one_r,

    // operand fields
    output logic [2:0]                 dst_reg_r,
    output logic [2:0]                 src_a_reg_r,
    output logic [2:0]                 src_b_reg_r,
    output logic                       src_a_high_r,
    output logic                       src_b_high_r,
    output logic [15:0]                low_bits_r
);

    // ****************************************************************
    // range table
    // ****************************************************************
    localparam int NUM = `MI_NUM_RANGES;

    // lower bounds, index order matches the form table below
    localparam logic [31:0] RANGE_LO [NUM] = '{
        `MI_LO_00, `MI_LO_01, `MI_LO_02, `MI_LO_03, `MI_LO_04,
        `MI_LO_05, `MI_LO_06, `MI_LO_07, `MI_LO_08, `MI_LO_09,
        `MI_LO_10, `MI_LO_11, `MI_LO_12, `MI_LO_13, `MI_LO_14,
        `MI_LO_15, `MI_LO_16, `MI_LO_17, `MI_LO_18, `MI_LO_19,
        `MI_LO_20, `MI_LO_21, `MI_LO_22, `MI_LO_23, `MI_LO_24,
        `MI_LO_25
    };

    // upper bounds, inclusive
    localparam logic [31:0] RANGE_HI [NUM] = '{
        `MI_HI_00, `MI_HI_01, `MI_HI_02, `MI_HI_03, `MI_HI_04,
        `MI_HI_05, `MI_HI_06, `MI_HI_07, `MI_HI_08, `MI_HI_09,
        `MI_HI_10, `MI_HI_11, `MI_HI_12, `MI_HI_13, `MI_HI_14,
        `MI_HI_15, `MI_HI_16, `MI_HI_17, `MI_HI_18, `MI_HI_19,
        `MI_HI_20, `MI_HI_21, `MI_HI_22, `MI_HI_23, `MI_HI_24,
        `MI_HI_25
    };

    // ****************************************************************
    // form table
    // ****************************************************************
    // maps a range index to its form; an index past the table
    // yields the empty form so a bad index can never decode
    function automatic mac_int_pkg::form_s form_of(input int idx);
        mac_int_pkg::form_s f;

        f = '{mac_int_pkg::DST_NONE, mac_int_pkg::OP_NONE,
              mac_int_pkg::OPT_NONE, 1'b0};

        unique case (idx)
            // signed integer into even register
            0: f = '{mac_int_pkg::DST_EVEN, mac_int_pkg::OP_ASSIGN,
                     mac_int_pkg::OPT_SIGNED_INTEGER, 1'b0};
            1: f = '{mac_int_pkg::DST_EVEN, mac_int_pkg::OP_ADD,
                     mac_int_pkg::OPT_SIGNED_INTEGER, 1'b0};
            2: f = '{mac_int_pkg::DST_EVEN, mac_int_pkg::OP_SUB,
                     mac_int_pkg::OPT_SIGNED_INTEGER, 1'b0};

            // signed integer, mixed, odd register and paired even/odd
            3: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_ASSIGN,
                     mac_int_pkg::OPT_SIGNED_INTEGER, 1'b1};
            4: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_ADD,
                     mac_int_pkg::OPT_SIGNED_INTEGER, 1'b1};
            5: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_SUB,
                     mac_int_pkg::OPT_SIGNED_INTEGER, 1'b1};
            6: f = '{mac_int_pkg::DST_EVEN_ODD,
                     mac_int_pkg::OP_PER_LANE,
                     mac_int_pkg::OPT_SIGNED_INTEGER, 1'b1};

            // scaled by two, low half and paired half move
            7: f = '{mac_int_pkg::DST_HALF_LOW, mac_int_pkg::OP_ASSIGN,
                     mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};
            8: f = '{mac_int_pkg::DST_HALF_LOW, mac_int_pkg::OP_ADD,
                     mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};
            9: f = '{mac_int_pkg::DST_HALF_LOW, mac_int_pkg::OP_SUB,
                     mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};
            10: f = '{mac_int_pkg::DST_LOW_HIGH, mac_int_pkg::OP_MOVE,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};

            // scaled by two, odd register
            11: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_ASSIGN,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};
            12: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_ADD,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};
            13: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_SUB,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};

            // scaled by two, even register
            14: f = '{mac_int_pkg::DST_EVEN, mac_int_pkg::OP_ADD,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};
            15: f = '{mac_int_pkg::DST_EVEN, mac_int_pkg::OP_SUB,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b0};

            // scaled by two, mixed operands
            16: f = '{mac_int_pkg::DST_HALF_HIGH, mac_int_pkg::OP_ASSIGN,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b1};
            17: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_ASSIGN,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b1};
            18: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_ADD,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b1};
            19: f = '{mac_int_pkg::DST_ODD, mac_int_pkg::OP_SUB,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b1};
            20: f = '{mac_int_pkg::DST_EVEN_ODD,
                      mac_int_pkg::OP_PER_LANE,
                      mac_int_pkg::OPT_SIGNED_INTEGER_X2, 1'b1};

            // integer upper half option
            21: f = '{mac_int_pkg::DST_HALF_LOW, mac_int_pkg::OP_ASSIGN,
                      mac_int_pkg::OPT_INTEGER_UPPER_HALF, 1'b0};
            22: f = '{mac_int_pkg::DST_HALF_LOW, mac_int_pkg::OP_ADD,
                      mac_int_pkg::OPT_INTEGER_UPPER_HALF, 1'b0};
            23: f = '{mac_int_pkg::DST_HALF_LOW, mac_int_pkg::OP_SUB,
                      mac_int_pkg::OPT_INTEGER_UPPER_HALF, 1'b0};
            24: f = '{mac_int_pkg::DST_HALF_HIGH, mac_int_pkg::OP_ADD,
                      mac_int_pkg::OPT_INTEGER_UPPER_HALF, 1'b0};

            // signed integer, mixed, high half subtract
            25: f = '{mac_int_pkg::DST_HALF_HIGH, mac_int_pkg::OP_SUB,
                      mac_int_pkg::OPT_SIGNED_INTEGER, 1'b1};
            default: f = '{mac_int_pkg::DST_NONE, mac_int_pkg::OP_NONE,
                           mac_int_pkg::OPT_NONE, 1'b0};
        endcase
        return f;
    endfunction

    // ****************************************************************
    // range comparators
    // ****************************************************************
    logic [NUM-1:0] hit;        // one bit per range

    // the ranges do not overlap, so at most one bit is set
    for (genvar g = 0; g < NUM; g++) begin : g_range
        opcode_range_match #(
            .LO (RANGE_LO[g]),
            .HI (RANGE_HI[g])
        ) u_match (
            .opcode (opcode),
            .hit    (hit[g])
        );
    end

    // ****************************************************************
    // operand field extraction
    // ****************************************************************
    logic [2:0] dst_reg;        // destination register number
    logic [2:0] src_a_reg;      // first source register number
    logic [2:0] src_b_reg;      // second source register number
    logic       src_a_high;     // first source uses its high half
    logic       src_b_high;     // second source uses its high half

    mac_operand_fields u_fields (
        .opcode     (opcode),
        .dst_reg    (dst_reg),
        .src_a_reg  (src_a_reg),
        .src_b_reg  (src_b_reg),
        .src_a_high (src_a_high),
        .src_b_high (src_b_high)
    );

    // ****************************************************************
    // match selection
    // ****************************************************************
    logic               any_hit;    // opcode falls in some range
    mac_int_pkg::form_s form_nxt;   // form of the matching range

    // lowest index wins; a priority scan keeps the logic well defined
    // even though overlapping ranges cannot occur in this table
    always_comb begin
        any_hit  = 1'b0;
        form_nxt = form_of(NUM);

        for (int i = 0; i < NUM; i++) begin
            if (!any_hit && hit[i]) begin
                any_hit  = 1'b1;
                form_nxt = form_of(i);
            end
        end
    end

    // ****************************************************************
    // decode outcome flags
    // ****************************************************************
    // exactly one of the two flags pulses per valid opcode
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            form_valid_r  <= 1'b0;
            other_valid_r <= 1'b0;
        end else begin
            form_valid_r  <= opcode_valid && any_hit;
            other_valid_r <= opcode_valid && !any_hit;
        end
    end

    // ****************************************************************
    // other-range hand-off word
    // ****************************************************************
    // the whole opcode goes on so the other decoders see it intact
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            other_opcode_r <= 32'h0000_0000;
        end else if (opcode_valid && !any_hit) begin
            other_opcode_r <= opcode;
        end
    end

    // ****************************************************************
    // form description
    // ****************************************************************
    // held while idle so the datapath sees stable controls;
    // an unmatched opcode clears the form to the empty one
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dest_r         <= mac_int_pkg::DST_NONE;
            op_r           <= mac_int_pkg::OP_NONE;
            option_r       <= mac_int_pkg::OPT_NONE;
            mixed_r        <= 1'b0;
            use_acc_zero_r <= 1'b0;
            use_acc_one_r  <= 1'b0;
        end else if (opcode_valid) begin
            dest_r   <= form_nxt.dest;
            op_r     <= form_nxt.op;
            option_r <= form_nxt.option;
            mixed_r  <= form_nxt.mixed;

            // accumulator_zero feeds low and even results
            use_acc_zero_r <= form_nxt.dest inside {
                mac_int_pkg::DST_HALF_LOW, mac_int_pkg::DST_EVEN,
                mac_int_pkg::DST_EVEN_ODD, mac_int_pkg::DST_LOW_HIGH};

            // accumulator_one feeds high and odd results
            use_acc_one_r <= form_nxt.dest inside {
                mac_int_pkg::DST_HALF_HIGH, mac_int_pkg::DST_ODD,
                mac_int_pkg::DST_EVEN_ODD, mac_int_pkg::DST_LOW_HIGH};
        end
    end

    // ****************************************************************
    // operand fields
    // ****************************************************************
    // fields are copied untouched; only matched opcodes load them so
    // a foreign opcode cannot disturb the datapath's operand view
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dst_reg_r    <= 3'h0;
            src_a_reg_r  <= 3'h0;
            src_b_reg_r  <= 3'h0;
            src_a_high_r <= 1'b0;
            src_b_high_r <= 1'b0;
            low_bits_r   <= 16'h0000;
        end else if (opcode_valid && any_hit) begin
            dst_reg_r    <= dst_reg;
            src_a_reg_r  <= src_a_reg;
            src_b_reg_r  <= src_b_reg;
            src_a_high_r <= src_a_high;
            src_b_high_r <= src_b_high;
            low_bits_r   <= opcode[15:0];
        end
    end

endmodule

`default_nettype wire

// file: dv/mac_int_checker.sv
// assertion checker for the integer mac opcode decoder
`default_nettype none
// ********************
// port checks
// ********************
module mac_int_checker (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 arst_n,
    // opcode in
    input wire logic                 opcode_valid,
    input wire logic [31:0]          opcode,
    // decode out
    input wire logic                 form_valid_r,
    input wire logic                 other_valid_r,
    input wire logic [31:0]          other_opcode_r,
    input wire mac_int_pkg::dest_e   dest_r,
    input wire mac_int_pkg::option_e option_r,
    input wire logic                 mixed_r,
    input wire logic                 use_acc_one_r,
    input wire logic [2:0]           dst_reg_r,
    input wire logic [15:0]          low_bits_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // one answer per taken opcode, never both flags
    property p_one_flag; opcode_valid |=> form_valid_r ^ other_valid_r;
    endproperty
    a_one_flag: assert property (p_one_flag)
        else $error("taken opcode without exactly one flag");
    property p_no_flag; !opcode_valid |=> !(form_valid_r || other_valid_r);
    endproperty
    a_no_flag: assert property (p_no_flag)
        else $error("flag without a taken opcode");
    // operand bits pass straight through
    property p_low_pass; form_valid_r |-> low_bits_r == $past(opcode[15:0])
        && dst_reg_r == $past(opcode[8:6]); endproperty
    a_low_pass: assert property (p_low_pass)
        else $error("operand bits altered");
    property p_other; other_valid_r |-> other_opcode_r == $past(opcode)
        && dest_r == mac_int_pkg::DST_NONE; endproperty
    a_other: assert property (p_other)
        else $error("unmatched opcode badly reported");
    property p_even_si; opcode_valid &&
        opcode inside {[32'hc10d_0000:32'hc10d_17ff]}
        |=> dest_r == mac_int_pkg::DST_EVEN
        && option_r == mac_int_pkg::OPT_SIGNED_INTEGER; endproperty
    a_even_si: assert property (p_even_si)
        else $error("even register integer form missed");
    property p_odd_x2; opcode_valid && opcode[31:16] inside {16'hc128,
        16'hc129, 16'hc12a} && opcode[15:0] inside {[16'h1800:16'hd9ff]}
        |=> use_acc_one_r && option_r == mac_int_pkg::OPT_SIGNED_INTEGER_X2;
    endproperty
    a_odd_x2: assert property (p_odd_x2)
        else $error("odd register scaled form missed");
    property p_vec_x2m; opcode_valid &&
        opcode inside {[32'hc13c_2000:32'hc13f_ffff]}
        |=> dest_r == mac_int_pkg::DST_EVEN_ODD && mixed_r; endproperty
    a_vec_x2m: assert property (p_vec_x2m)
        else $error("paired mixed vector form missed");
    property p_low_uh; opcode_valid &&
        opcode inside {[32'hc163_2000:32'hc163_37ff]}
        |=> form_valid_r ##0 option_r == mac_int_pkg::OPT_INTEGER_UPPER_HALF;
    endproperty
    a_low_uh: assert property (p_low_uh)
        else $error("upper half low result form missed");
endmodule
bind mac_opcode_decoder_int_modes mac_int_checker chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .opcode_valid(opcode_valid),
    .opcode(opcode), .form_valid_r(form_valid_r), .dest_r(dest_r),
    .other_valid_r(other_valid_r), .other_opcode_r(other_opcode_r),
    .option_r(option_r), .mixed_r(mixed_r), .use_acc_one_r(use_acc_one_r),
    .dst_reg_r(dst_reg_r), .low_bits_r(low_bits_r));
`default_nettype wire

// file: dv/opcode_source.sv
// sequencer model that presents opcodes to the decoder
`default_nettype none
module opcode_source (
    // clock
    input wire logic        ref_clk,
    // opcode out
    output var logic        opcode_valid,
    output var logic [31:0] opcode
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        opcode_valid = 1'b0;
        opcode       = 32'h0000_0000;
    end
    // drive just after an edge; the word is taken at the next edge
    task automatic issue(input logic [31:0] op);
        @(posedge ref_clk);
        #1;
        opcode_valid = 1'b1;
        opcode       = op;
    endtask
    // idle word flips so a stale value can never pass for a new one
    task automatic idle();
        @(posedge ref_clk);
        #1;
        opcode_valid = 1'b0;
        opcode       = ~opcode;
    endtask
endmodule
`default_nettype wire

// file: dv/mac_opcode_decoder_int_modes_test.sv
// self-checking bench for the integer mac opcode decoder
`default_nettype none
module mac_opcode_decoder_int_modes_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, arst_n, opcode_valid, form_valid_r, other_valid_r, mixed_r;
    logic use_acc_zero_r, use_acc_one_r, src_a_high_r, src_b_high_r;
    logic [31:0] opcode, other_opcode_r;
    logic [2:0] dst_reg_r, src_a_reg_r, src_b_reg_r;
    logic [15:0] low_bits_r;
    mac_int_pkg::dest_e dest_r;
    mac_int_pkg::op_e op_r;
    mac_int_pkg::option_e option_r;
    int miscompares = 0;
    int samples_checked = 0;
    // lo bound, hi bound, nibbles: dest, operator, option, mixed
    localparam logic [79:0] rows [26] = '{
        80'hc10d0000_c10d07ff_3110, 80'hc10d0800_c10d0fff_3210,
        80'hc10d1000_c10d17ff_3310, 80'hc1181800_c118d9ff_4111,
        80'hc1191800_c119d9ff_4211, 80'hc11a1800_c11ad9ff_4311,
        80'hc11c2000_c11fffff_5411, 80'hc1232000_c12327ff_1120,
        80'hc1232800_c1232fff_1220, 80'hc1233000_c12337ff_1320,
        80'hc1273800_c12739c0_6520, 80'hc1281800_c128d9ff_4120,
        80'hc1291800_c129d9ff_4220, 80'hc12a1800_c12ad9ff_4320,
        80'hc12d0800_c12d0fff_3220, 80'hc12d1000_c12d17ff_3320,
        80'hc1341800_c134d9ff_2121, 80'hc1381800_c138d9ff_4121,
        80'hc1391800_c139d9ff_4221, 80'hc13a1800_c13ad9ff_4321,
        80'hc13c2000_c13fffff_5421, 80'hc1632000_c16327ff_1130,
        80'hc1632800_c1632fff_1230, 80'hc1633000_c16337ff_1330,
        80'hc1651800_c165d9ff_2230, 80'hc1161800_c116d9ff_2311};
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    opcode_source src (.ref_clk(ref_clk), .opcode_valid(opcode_valid),
        .opcode(opcode));
    mac_opcode_decoder_int_modes uut (.ref_clk(ref_clk), .arst_n(arst_n),
        .opcode_valid(opcode_valid), .opcode(opcode), .mixed_r(mixed_r),
        .form_valid_r(form_valid_r), .other_valid_r(other_valid_r),
        .other_opcode_r(other_opcode_r), .dest_r(dest_r), .op_r(op_r),
        .option_r(option_r), .use_acc_zero_r(use_acc_zero_r),
        .use_acc_one_r(use_acc_one_r), .dst_reg_r(dst_reg_r),
        .src_a_reg_r(src_a_reg_r), .src_b_reg_r(src_b_reg_r),
        .src_a_high_r(src_a_high_r), .src_b_high_r(src_b_high_r),
        .low_bits_r(low_bits_r));
    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // matched form: flags, form, accumulators and the operand fields
    task automatic expect_form(input logic [79:0] row, input logic [31:0] op);
        logic [15:0] f;
        f = row[15:0];
        check("flags", 32'({form_valid_r, other_valid_r}), 32'h2);
        check("form", 32'({dest_r, op_r, option_r, mixed_r}),
            32'({f[14:12], f[10:8], f[5:4], f[0]}));
        check("acc", 32'({use_acc_zero_r, use_acc_one_r}), 32'({f[14:12]
            inside {3'h1, 3'h3, 3'h5, 3'h6}, f[14:12] inside {3'h2, 3'h4,
            3'h5, 3'h6}}));
        check("fields", 32'({src_a_high_r, src_b_high_r, dst_reg_r,
            src_a_reg_r, src_b_reg_r, low_bits_r}), 32'({op[10:9], op[8:0],
            op[15:0]}));
    endtask
    // both bounds of every range, back to back
    task automatic t_ranges();
        logic [31:0] prev;
        for (int j = 0; j < 52; j++) begin
            src.issue(j[0] ? rows[j/2][47:16] : rows[j/2][79:48]);
            if (j > 0) expect_form(rows[(j-1)/2], prev);
            prev = j[0] ? rows[j/2][47:16] : rows[j/2][79:48];
        end
        src.idle();
        expect_form(rows[25], prev);
    endtask
    // words outside the ranges, all but one adjacent to a bound, with idle gaps between
    task automatic t_unmatched();
        logic [31:0] outs [8] = '{32'hc10d_1800, 32'hc12d_0000, 32'hc123_1fff,
            32'hc127_39c1, 32'hc140_0000, 32'hc116_da00, 32'hc163_3800,
            32'hc165_17ff};
        foreach (outs[i]) begin
            src.issue(outs[i]);
            src.idle();
            check("other", 32'({form_valid_r, other_valid_r}), 32'h1);
            check("empty", 32'({dest_r, op_r, option_r, low_bits_r}),
                32'(16'hd9ff));
            src.idle();
            check("held", other_opcode_r, outs[i]);
            check("idle", 32'({form_valid_r, other_valid_r}), 32'h0);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        check("reset", 32'({form_valid_r, other_valid_r, dest_r, low_bits_r}),
            32'h0);
        #1 arst_n = 1'b1;
        t_ranges();
        t_unmatched();
        tally_and_finish();
    end
    // cut a hang short well past the expected run length
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
